/* src/dhk_pkg.sv */
// dhk_pkg: shared constants for the decimal/hex keypad entry block
// assumes: 100 MHz aclk, AXI4-Lite register access
package dhk_pkg;
    localparam int DHK_NUM_DIGIT_KEYS = 10;
    localparam int DHK_NUM_FUNC_KEYS  = 6;
    localparam int DHK_NUM_KEYS       = 16;
    localparam int DHK_MATRIX_LINES   = 4;
    // bus register byte addresses
    localparam logic [7:0] DHK_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] DHK_KEYS_ADDR   = 8'h04;
    localparam logic [7:0] DHK_RESULT_ADDR = 8'h08;
    localparam logic [7:0] DHK_IRQ_STAT    = 8'h0C;
    localparam logic [7:0] DHK_IRQ_EN      = 8'h10;
    localparam logic [7:0] DHK_IRQ_CLR     = 8'h14;
    localparam logic [7:0] DHK_FLAGS_ADDR  = 8'h18;
    // control register fields
    localparam int DHK_CTRL_ENABLE = 0;
    localparam int DHK_CTRL_MATRIX = 1;
    localparam int DHK_CTRL_WIDE   = 2;
    localparam int DHK_CTRL_CLEAR  = 3;
    localparam logic [31:0] DHK_CTRL_RESET = 32'h0000_0000;
    // interrupt status fields
    localparam int DHK_IRQ_DIGIT = 0;
    localparam int DHK_IRQ_FUNC  = 1;
    localparam int DHK_IRQ_BITS  = 2;
    // result limits
    localparam logic [31:0] DHK_MAX_NARROW = 32'h0000_270F;
    localparam logic [31:0] DHK_MAX_WIDE   = 32'h05F5_E0FF;
    // scan dwell per drive line
    localparam int DHK_SCAN_DWELL_NS = 1000;
    localparam int DHK_CLK_PERIOD_NS = 10;
    localparam int DHK_SCAN_DWELL_CYC = DHK_SCAN_DWELL_NS / DHK_CLK_PERIOD_NS;
    localparam logic [1:0] DHK_RESP_OKAY   = 2'b00;
    localparam logic [1:0] DHK_RESP_SLVERR = 2'b10;
endpackage : dhk_pkg

/* src/dhk_sync.sv */
// dhk_sync: two-flop synchroniser for a bundle of pin levels
// assumes: inputs asynchronous to aclk
`timescale 1ns/1ns
module dhk_sync #(
    parameter int W = 10
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule : dhk_sync

/* src/dhk_accum.sv */
// dhk_accum: decimal digit accumulator for the result register
// assumes: digit_valid is a one-cycle pulse on aclk
`timescale 1ns/1ns
module dhk_accum
    import dhk_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        digit_valid,
    input  wire logic [3:0]  digit,
    input  wire logic        wide,
    input  wire logic        clear,
    output logic      [31:0] result
);
    logic [31:0] result_r;
    logic [31:0] result_nxt;
    logic [31:0] shifted;
    logic [31:0] limit;

    function automatic logic [31:0] dhk_times_ten_mod(input logic [31:0] v,
                                                      input logic [31:0] m);
        logic [35:0] t;
        t = {4'h0, v} * 36'd10;
        return 32'(t % {4'h0, m});
    endfunction : dhk_times_ten_mod

    assign limit = wide ? DHK_MAX_WIDE : DHK_MAX_NARROW;
    // shift one digit, drop the top
    assign shifted = dhk_times_ten_mod(result_r, limit + 32'h0000_0001) + {28'h0, digit};
    assign result_nxt = clear ? 32'h0000_0000 :
                        digit_valid ? shifted : result_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_r <= 32'h0000_0000;
        end else begin
            result_r <= result_nxt;
        end
    end

    assign result = result_r;

    a_result_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        result_r <= DHK_MAX_WIDE)
        else $error("result above eight digits");
    a_shift_insert: assert property (@(posedge aclk) disable iff (!aresetn)
        digit_valid && !clear |=> result_r % 32'd10 == 32'($past(digit)))
        else $error("new digit not in lowest place");
endmodule : dhk_accum

/* src/dhk_keypad.sv */
// dhk_keypad: keypad entry, direct ten-key or 4x4 scanned matrix, AXI4-Lite regs
// assumes: key pins asynchronous to aclk, drive outputs are open-collector style
// Behaviour
// - direct mode: one dedicated input per numeric key, no multiplexing
// - matrix mode: four sense inputs and four drive outputs read sixteen keys
// - matrix keys zero to nine are digits, six are function keys
// - digit and function key handling never affect each other
// - scan matrix from first sense input and first drive output while enabled in matrix mode
// - status relays: ten digit states first, then function keys A to F
// - function key pressed output high while any of A to F is held
// - result limited to 9999 narrow, 99999999 wide
// - six function keys in matrix mode, none in direct mode, either result width
// - enable low: no processing, key press and status relays held zero
// - dropping enable leaves the result unchanged
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
module dhk_keypad
    import dhk_pkg::*;
#(
    parameter int DWELL = DHK_SCAN_DWELL_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [9:0]  direct_decimal_key_entry,
    input  wire logic [3:0]  matrix_key_entry,
    output logic      [3:0]  first_drive_output,
    output logic             key_press_pulse,
    output logic             numeric_key_pressed,
    output logic             function_key_pressed,
    output logic      [15:0] key_status_relays,
    output logic      [31:0] result,
    output logic             irq
);
    typedef enum logic [1:0] {DHK_IDLE, DHK_HELD} dhk_key_t;

    logic [31:0] ctrl_r;
    logic [DHK_IRQ_BITS-1:0] irq_stat_r;
    logic [DHK_IRQ_BITS-1:0] irq_en_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    logic [9:0]  direct_s;
    logic [3:0]  sense_s;
    logic [1:0]  line_r;
    logic [$clog2(DWELL+1)-1:0] dwell_r;
    logic [15:0] matrix_r;
    logic [15:0] relays_r;
    dhk_key_t    key_st_r;
    logic [3:0]  held_digit_r;
    logic        press_r;
    logic        digit_valid;
    logic [3:0]  digit_val;
    logic        ctrl_clear;

    wire enable   = ctrl_r[DHK_CTRL_ENABLE];
    wire mode_mat = ctrl_r[DHK_CTRL_MATRIX];
    wire wide     = ctrl_r[DHK_CTRL_WIDE];

    // ---- pins through synchronisers
    dhk_sync #(.W(10)) u_sync_direct (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (direct_decimal_key_entry),
        .dout    (direct_s)
    );
    dhk_sync #(.W(4)) u_sync_sense (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (matrix_key_entry),
        .dout    (sense_s)
    );

    // ---- matrix scan
    wire dwell_done = (dwell_r == ($bits(dwell_r))'(DWELL - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable || !mode_mat) begin
            dwell_r <= '0;
            line_r  <= 2'h0;
        end else if (dwell_done) begin
            dwell_r <= '0;
            // step to the next drive line
            line_r  <= line_r + 2'h1;
        end else begin
            dwell_r <= dwell_r + 1'b1;
        end
    end

    // drive one line from the first output
    assign first_drive_output = (enable && mode_mat) ? (4'h1 << line_r) : 4'h0;

    // sample four sense lines at end of dwell
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable || !mode_mat) begin
            matrix_r <= 16'h0000;
        end else if (dwell_done) begin
            matrix_r[line_r*4 +: 4] <= sense_s;
        end
    end

    // key index = line*4 + sense; 0..9 digits, 10..15 function keys A..F
    // direct mode uses dedicated digit inputs
    wire [15:0] keys_now = !enable  ? 16'h0000 :
                           mode_mat ? matrix_r : {6'h00, direct_s};

    function automatic logic [3:0] dhk_first_set(input logic [9:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 9; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : dhk_first_set

    wire [9:0] digit_keys = keys_now[9:0];
    // six function keys in both widths
    wire [5:0] func_keys  = keys_now[15:10];
    wire       any_digit  = |digit_keys;

    // ---- digit key tracking, one entry per press
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            key_st_r     <= DHK_IDLE;
            held_digit_r <= 4'h0;
            press_r      <= 1'b0;
        end else begin
            press_r <= 1'b0;
            unique case (key_st_r)
                DHK_IDLE: begin
                    if (any_digit) begin
                        key_st_r     <= DHK_HELD;
                        held_digit_r <= dhk_first_set(digit_keys);
                        press_r      <= 1'b1;
                    end
                end
                DHK_HELD: begin
                    if (!digit_keys[held_digit_r]) begin
                        key_st_r <= DHK_IDLE;
                    end
                end
            endcase
        end
    end

    // no entry in the cycle enable drops
    assign digit_valid = press_r && enable;
    assign digit_val   = held_digit_r;

    // ---- status relays
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            relays_r <= 16'h0000;
        end else begin
            if (press_r) begin
                relays_r[9:0] <= 10'h001 << held_digit_r;
            end
            // function keys in upper six positions
            relays_r[15:10] <= func_keys;
        end
    end

    dhk_accum u_accum (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .digit_valid (digit_valid),
        .digit       (digit_val),
        .wide        (wide),
        .clear       (ctrl_clear),
        .result      (result)
    );

    assign key_status_relays    = relays_r;
    assign key_press_pulse      = digit_valid;
    assign numeric_key_pressed  = (key_st_r == DHK_HELD);
    // any of A to F held
    assign function_key_pressed = |relays_r[15:10];

    // ---- AXI4-Lite slave
    wire aw_take  = s_axi_awvalid && !aw_got_r && !bvalid_r;
    wire w_take   = s_axi_wvalid && !w_got_r && !bvalid_r;
    wire aw_have  = aw_got_r || aw_take;
    wire w_have   = w_got_r || w_take;
    wire wr_fire  = aw_have && w_have && !bvalid_r;
    wire [7:0] wa = aw_take ? s_axi_awaddr[7:0] : aw_addr_r;
    wire [31:0] wd = w_take ? s_axi_wdata : w_data_r;
    wire [3:0] ws = w_take ? s_axi_wstrb : w_strb_r;
    wire wr_ctrl  = wr_fire && (wa == DHK_CTRL_ADDR);
    wire wr_en    = wr_fire && (wa == DHK_IRQ_EN);
    wire wr_clr   = wr_fire && (wa == DHK_IRQ_CLR) && ws[0];
    wire wr_ok    = (wa == DHK_CTRL_ADDR) || (wa == DHK_IRQ_EN) || (wa == DHK_IRQ_CLR);
    assign ctrl_clear = wr_ctrl && ws[0] && wd[DHK_CTRL_CLEAR];
    wire [31:0] strb_mask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= DHK_RESP_OKAY;
        end else begin
            if (aw_take) aw_addr_r <= s_axi_awaddr[7:0];
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_got_r <= wr_fire ? 1'b0 : aw_have;
            w_got_r  <= wr_fire ? 1'b0 : w_have;
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? DHK_RESP_OKAY : DHK_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r   <= DHK_CTRL_RESET;
            irq_en_r <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= ((ctrl_r & ~strb_mask) | (wd & strb_mask)) & 32'h0000_0007;
            end
            if (wr_en && ws[0]) begin
                irq_en_r <= wd[DHK_IRQ_BITS-1:0];
            end
        end
    end

    // sticky events, a new event wins over a clear
    wire [DHK_IRQ_BITS-1:0] irq_evt = {|(func_keys & ~relays_r[15:10]), digit_valid};
    wire [DHK_IRQ_BITS-1:0] irq_wclr = wr_clr ? wd[DHK_IRQ_BITS-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_wclr) | irq_evt;
        end
    end
    assign irq = |(irq_stat_r & irq_en_r);

    wire [31:0] rd_mux =
        (s_axi_araddr[7:0] == DHK_CTRL_ADDR)   ? ctrl_r :
        (s_axi_araddr[7:0] == DHK_KEYS_ADDR)   ? {16'h0000, relays_r} :
        (s_axi_araddr[7:0] == DHK_RESULT_ADDR) ? result :
        (s_axi_araddr[7:0] == DHK_IRQ_STAT)    ? {30'h0, irq_stat_r} :
        (s_axi_araddr[7:0] == DHK_IRQ_EN)      ? {30'h0, irq_en_r} :
        (s_axi_araddr[7:0] == DHK_FLAGS_ADDR)  ?
            {29'h0, function_key_pressed, numeric_key_pressed, key_press_pulse} :
        32'h0000_0000;
    wire rd_ok = (s_axi_araddr[7:0] <= DHK_FLAGS_ADDR) && (s_axi_araddr[1:0] == 2'b00)
                 && (s_axi_araddr[7:0] != DHK_IRQ_CLR);
    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= DHK_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_ok ? DHK_RESP_OKAY : DHK_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !key_press_pulse && key_status_relays == 16'h0000)
        else $error("activity while disabled");
    a_result_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable && !ctrl_clear |=> $stable(result))
        else $error("result changed while disabled");
    a_one_hot_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && mode_mat |-> $onehot(first_drive_output))
        else $error("drive lines not one hot");
    a_drive_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !(enable && mode_mat) |-> first_drive_output == 4'h0)
        else $error("drive active outside matrix mode");
    a_func_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        function_key_pressed == |key_status_relays[15:10])
        else $error("function flag mismatch");
    a_func_indep: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && $stable(func_keys) |=> $stable(key_status_relays[15:10]))
        else $error("function relays disturbed");
    a_direct_no_fn: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && !mode_mat |-> func_keys == 6'h00)
        else $error("function keys in direct mode");
    a_press_single: assert property (@(posedge aclk) disable iff (!aresetn)
        key_press_pulse |=> !key_press_pulse)
        else $error("press pulse too long");
    a_scan_step: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && mode_mat && dwell_done |=> enable && mode_mat
            |-> line_r == $past(line_r) + 2'h1)
        else $error("scan did not advance");
    a_relay_digit: assert property (@(posedge aclk) disable iff (!aresetn)
        key_press_pulse |=> $onehot(key_status_relays[9:0]) || !enable)
        else $error("digit relay not set");

    c_direct_entry: cover property (@(posedge aclk) key_press_pulse && !mode_mat);
    c_matrix_entry: cover property (@(posedge aclk) key_press_pulse && mode_mat);
    c_func_key:     cover property (@(posedge aclk) function_key_pressed);
    c_irq:          cover property (@(posedge aclk) irq);
endmodule : dhk_keypad

/* bench/dhk_keypad_model.sv */
// dhk_keypad_model: push-button 4x4 key matrix on the far side of the drive/sense pins
// assumes: sense lines pulled down, a held key joins its drive line to its sense line
`timescale 1ns/1ns
module dhk_keypad_model (
    input  wire logic [15:0] key_held,
    input  wire logic [3:0]  first_drive_output,
    output logic      [3:0]  matrix_key_entry
);
    logic [3:0] sense_w;
    // key index is drive line times four plus sense bit
    always_comb begin
        sense_w = 4'h0;
        for (int ln = 0; ln < 4; ln++) begin
            for (int sb = 0; sb < 4; sb++) begin
                if (first_drive_output[ln] && key_held[ln*4+sb]) begin
                    sense_w[sb] = 1'b1;
                end
            end
        end
    end
    // only a driven line reaches sense; pull-down otherwise
    assign matrix_key_entry = sense_w;
endmodule : dhk_keypad_model

/* bench/dhk_keypad_bench.sv */
// dhk_keypad_bench: self-checking bench for dhk_keypad with a matrix keypad model
// assumes: 100 MHz aclk, scan dwell shortened to DW cycles
`timescale 1ns/1ns
module dhk_keypad_bench;
    import dhk_pkg::*;
    // dwell must outlast the two-flop sense latency
    localparam int DW = 4;
    localparam int LIMIT = 40000;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        key_press_pulse, numeric_key_pressed, function_key_pressed;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, result;
    logic [3:0]  s_axi_wstrb, matrix_key_entry, first_drive_output;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [9:0]  direct_keys;
    logic [15:0] key_held, key_status_relays;
    logic [31:0] exp_val, seed, rd;
    logic        wide;
    int          err_count, n_compared, cyc;

    dhk_keypad #(.DWELL(DW)) dhk_keypad_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .direct_decimal_key_entry(direct_keys),
        .matrix_key_entry(matrix_key_entry), .first_drive_output(first_drive_output),
        .key_press_pulse(key_press_pulse), .numeric_key_pressed(numeric_key_pressed),
        .function_key_pressed(function_key_pressed), .key_status_relays(key_status_relays),
        .result(result), .irq(irq)
    );
    dhk_keypad_model dhk_keypad_model_inst (
        .key_held(key_held), .first_drive_output(first_drive_output),
        .matrix_key_entry(matrix_key_entry)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // decimal shift with high digits dropped at the width limit
    function automatic logic [31:0] acc_next(input logic [31:0] v, input logic [3:0] d,
                                             input logic w);
        logic [31:0] lim;
        lim = w ? 32'd100000000 : 32'd10000;
        return ((v * 32'd10) % lim) + {28'h0, d};
    endfunction : acc_next

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            final_report();
        end
    end

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, DHK_RESP_OKAY});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    task automatic press_digit(input logic [3:0] d, input logic matrix);
        if (matrix) key_held <= 16'h1 << d;
        else direct_keys <= 10'h1 << d;
        for (int i = 0; i < 100 && key_press_pulse !== 1'b1; i++) @(posedge aclk);
        check("key_press_pulse", {31'h0, key_press_pulse}, 32'h1);
        repeat (3) @(posedge aclk);
        exp_val = acc_next(exp_val, d, wide);
        check("result", result, exp_val);
        check("digit relays", {22'h0, key_status_relays[9:0]}, 32'h1 << d);
        check("numeric_key_pressed", {31'h0, numeric_key_pressed}, 32'h1);
        key_held <= 16'h0;
        direct_keys <= 10'h0;
        repeat (4 * DW + 12) @(posedge aclk);
    endtask : press_digit

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        direct_keys = 10'h0;
        key_held = 16'h0;
        {exp_val, wide, err_count, n_compared, cyc} = '0;
        seed = 32'h30E63C6C;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("reset outputs", {11'h0, key_status_relays, first_drive_output, irq}, 32'h0);
        check("reset result", result, 32'h0);
        axi_read(DHK_CTRL_ADDR, rd, rr);
        check("ctrl reset", rd, DHK_CTRL_RESET);
        axi_read(8'h1C, rd, rr);
        check("unmapped resp", {30'h0, rr}, {30'h0, DHK_RESP_SLVERR});
        check("unmapped data", rd, 32'h0);
        $display("test reset done");
        axi_write(DHK_IRQ_EN, 32'h1);
        axi_write(DHK_CTRL_ADDR, 32'h1);
        for (int n = 0; n < 6; n++) begin
            seed = lfsr_next(seed);
            press_digit(4'(seed % 10), 1'b0);
        end
        check("irq raised", {31'h0, irq}, 32'h1);
        axi_write(DHK_IRQ_CLR, 32'h3);
        check("irq cleared", {31'h0, irq}, 32'h0);
        press_digit(4'h0, 1'b0);
        check("irq again", {31'h0, irq}, 32'h1);
        axi_write(DHK_IRQ_EN, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        axi_read(DHK_IRQ_STAT, rd, rr);
        check("digit status", {31'h0, rd[DHK_IRQ_DIGIT]}, 32'h1);
        $display("test direct done");
        axi_write(DHK_CTRL_ADDR, 32'hD);
        wide = 1'b1;
        exp_val = 32'h0;
        repeat (2) @(posedge aclk);
        check("cleared result", result, 32'h0);
        for (int n = 0; n < 9; n++) press_digit(4'h9, 1'b0);
        check("wide limit", result, DHK_MAX_WIDE);
        $display("test wide done");
        axi_write(DHK_CTRL_ADDR, 32'hB);
        wide = 1'b0;
        exp_val = 32'h0;
        for (int n = 0; n < 3; n++) begin
            seed = lfsr_next(seed);
            press_digit(4'(seed % 10), 1'b1);
        end
        rd = {22'h0, key_status_relays[9:0]};
        for (int k = 0; k < 6; k++) begin
            key_held <= 16'h1 << (10 + k);
            for (int i = 0; i < 100 && function_key_pressed !== 1'b1; i++) @(posedge aclk);
            check("drive one hot", {31'h0, $onehot(first_drive_output)}, 32'h1);
            check("function_key_pressed", {31'h0, function_key_pressed}, 32'h1);
            repeat (2) @(posedge aclk);
            check("func relays", {26'h0, key_status_relays[15:10]}, 32'h1 << k);
            check("digit relays kept", {22'h0, key_status_relays[9:0]}, rd);
            check("result kept", result, exp_val);
            key_held <= 16'h0;
            repeat (4 * DW + 12) @(posedge aclk);
            check("function released", {31'h0, function_key_pressed}, 32'h0);
        end
        axi_read(DHK_IRQ_STAT, rd, rr);
        check("function status", {31'h0, rd[DHK_IRQ_FUNC]}, 32'h1);
        $display("test matrix done");
        key_held <= 16'h1 << 11;
        repeat (4 * DW + 12) @(posedge aclk);
        axi_write(DHK_CTRL_ADDR, 32'h2);
        key_held <= 16'h1 << 5;
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (i > 4) check("disabled pulse", {31'h0, key_press_pulse}, 32'h0);
        end
        check("disabled relays", {16'h0, key_status_relays}, 32'h0);
        check("disabled drive", {28'h0, first_drive_output}, 32'h0);
        check("disabled fkp", {31'h0, function_key_pressed}, 32'h0);
        check("result held", result, exp_val);
        key_held <= 16'h0;
        $display("test disable done");
        final_report();
    end
endmodule : dhk_keypad_bench
